// [slpg_pkg.sv]
/*
  Constants shared by the status lamp pattern generator: clock and time
  figures, pattern numbers, register offsets and field positions.
  Assumes a single 20 MHz system clock and a plain register port.
*/
`default_nettype none

package slpg_pkg;

  // Clock and the millisecond time base
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_CNT_W = 15;

  // Interval lengths in milliseconds
  localparam int DUR_W = 11;
  localparam logic [10:0] T_DIT_MS = 11'h050;     // 80 ms
  localparam logic [10:0] T_DAH_MS = 11'h0F0;     // 240 ms
  localparam logic [10:0] T_GAP_MS = 11'h0F0;     // 240 ms
  localparam logic [10:0] T_2HZ_OFF_MS = 11'h104; // 260 ms
  localparam logic [10:0] T_5HZ_MS = 11'h064;     // 100 ms
  localparam logic [10:0] T_1920_MS = 11'h780;
  localparam logic [10:0] T_1760_MS = 11'h6E0;
  localparam logic [10:0] T_1600_MS = 11'h640;
  localparam logic [10:0] T_1440_MS = 11'h5A0;
  localparam logic [10:0] T_1280_MS = 11'h500;
  localparam logic [10:0] T_1120_MS = 11'h460;
  localparam logic [10:0] T_STEADY_MS = 11'h001;
  localparam int MAX_SEGS = 6;

  // Pattern numbers, 1 to 14
  localparam logic [3:0] PAT_OFF = 4'h1;
  localparam logic [3:0] PAT_DIT = 4'h2;
  localparam logic [3:0] PAT_DAH = 4'h3;
  localparam logic [3:0] PAT_DIT_DIT = 4'h4;
  localparam logic [3:0] PAT_DIT_DAH = 4'h5;
  localparam logic [3:0] PAT_DAH_DIT = 4'h6;
  localparam logic [3:0] PAT_DAH_DAH = 4'h7;
  localparam logic [3:0] PAT_DIT3 = 4'h8;
  localparam logic [3:0] PAT_DIT_DIT_DAH = 4'h9;
  localparam logic [3:0] PAT_OCC_DAH = 4'hA;
  localparam logic [3:0] PAT_OCC_DAH_DAH = 4'hB;
  localparam logic [3:0] PAT_2HZ = 4'hC;
  localparam logic [3:0] PAT_5HZ = 4'hD;
  localparam logic [3:0] PAT_ON = 4'hE;

  localparam int NUM_LAMPS = 7;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LOG = 8'h04;
  localparam logic [7:0] REG_SYNC = 8'h08;
  localparam logic [7:0] REG_TRACK = 8'h0C;
  localparam logic [7:0] REG_SURVEY = 8'h10;
  localparam logic [7:0] REG_APP = 8'h14;
  localparam logic [7:0] REG_DEV = 8'h18;
  localparam logic [7:0] REG_LAMPS = 8'h1C;
  localparam logic [7:0] REG_PATS = 8'h20;

  // Field positions
  localparam int CTRL_HEART_BIT = 0;
  localparam int LOG_EN_BIT = 0;
  localparam int LOG_NEAR_BIT = 1;
  localparam int LOG_FULL_BIT = 2;
  localparam int SYNC_FAULT_BIT = 3;  // High phase event
  localparam int TRACK_FAULT_BIT = 3; // Bad health
  localparam int SURVEY_FAULT_BIT = 2; // Movement

  // Status codes
  localparam logic [2:0] SYNC_NONE = 3'h0;
  localparam logic [2:0] SYNC_COARSE = 3'h1;
  localparam logic [2:0] SYNC_FINE = 3'h2;
  localparam logic [2:0] SYNC_LOCKED = 3'h3;
  localparam logic [2:0] TRK_NONE = 3'h0;
  localparam logic [2:0] TRK_ACQ = 3'h1;
  localparam logic [2:0] TRK_TRACKING = 3'h2;
  localparam logic [2:0] TRK_REF = 3'h3;
  localparam logic [2:0] TRK_SELF = 3'h4;
  localparam logic [2:0] TRK_GOOD = 3'h5;
  localparam logic [1:0] SRV_OFF = 2'h0;
  localparam logic [1:0] SRV_INITIAL = 2'h1;
  localparam logic [1:0] SRV_FULL = 2'h2;
  localparam logic [1:0] SRV_MONITOR = 2'h3;

  // Reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [3:0] PAT_RST = PAT_OFF;

endpackage : slpg_pkg

`default_nettype wire

// [slpg_player.sv]
/*
  One lamp's pattern player: walks the lit/dark intervals of the selected
  pattern on a millisecond tick. Assumes tick is one cycle wide and on the
  same clock; pattern comes from registered logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module slpg_player (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tick,
  input wire logic [3:0] pattern,
  output logic lamp
);

  logic [3:0] pat_reg, pat_next;
  logic [2:0] idx_reg, idx_next;
  logic [10:0] ms_reg, ms_next;
  logic lamp_reg, lamp_next;
  logic [11:0] cur_seg;

  function automatic logic [11:0] lit(input logic [10:0] d);
    lit = {1'b1, d};
  endfunction : lit

  function automatic logic [11:0] dark(input logic [10:0] d);
    dark = {1'b0, d};
  endfunction : dark

  // Segment table: {level, length}; a zero length ends the pattern
  function automatic logic [11:0] seg_of(input logic [3:0] p, input logic [2:0] i);
    logic [11:0] s;
    s = 12'h000;
    case (p)
      slpg_pkg::PAT_ON: if (i == 3'h0) s = lit(slpg_pkg::T_STEADY_MS);
      slpg_pkg::PAT_DIT: case (i)
        3'h0: s = lit(slpg_pkg::T_DIT_MS);
        3'h1: s = dark(slpg_pkg::T_1920_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DAH: case (i)
        3'h0: s = lit(slpg_pkg::T_DAH_MS);
        3'h1: s = dark(slpg_pkg::T_1760_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DIT_DIT: case (i)
        3'h0: s = lit(slpg_pkg::T_DIT_MS);
        3'h1: s = dark(slpg_pkg::T_GAP_MS);
        3'h2: s = lit(slpg_pkg::T_DIT_MS);
        3'h3: s = dark(slpg_pkg::T_1600_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DIT_DAH: case (i)
        3'h0: s = lit(slpg_pkg::T_DIT_MS);
        3'h1: s = dark(slpg_pkg::T_GAP_MS);
        3'h2: s = lit(slpg_pkg::T_DAH_MS);
        3'h3: s = dark(slpg_pkg::T_1440_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DAH_DIT: case (i)
        3'h0: s = lit(slpg_pkg::T_DAH_MS);
        3'h1: s = dark(slpg_pkg::T_GAP_MS);
        3'h2: s = lit(slpg_pkg::T_DIT_MS);
        3'h3: s = dark(slpg_pkg::T_1440_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DAH_DAH: case (i)
        3'h0: s = lit(slpg_pkg::T_DAH_MS);
        3'h1: s = dark(slpg_pkg::T_GAP_MS);
        3'h2: s = lit(slpg_pkg::T_DAH_MS);
        3'h3: s = dark(slpg_pkg::T_1280_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_DIT3, slpg_pkg::PAT_DIT_DIT_DAH: case (i)
        3'h0, 3'h2: s = lit(slpg_pkg::T_DIT_MS);
        3'h1, 3'h3: s = dark(slpg_pkg::T_GAP_MS);
        3'h4: s = lit((p == slpg_pkg::PAT_DIT3) ? slpg_pkg::T_DIT_MS : slpg_pkg::T_DAH_MS);
        3'h5: s = dark((p == slpg_pkg::PAT_DIT3) ? slpg_pkg::T_1280_MS : slpg_pkg::T_1120_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_OCC_DAH: case (i)
        3'h0: s = dark(slpg_pkg::T_GAP_MS);
        3'h1: s = lit(slpg_pkg::T_1760_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_OCC_DAH_DAH: case (i)
        3'h0: s = dark(slpg_pkg::T_GAP_MS);
        3'h1: s = lit(slpg_pkg::T_DAH_MS);
        3'h2: s = dark(slpg_pkg::T_GAP_MS);
        3'h3: s = lit(slpg_pkg::T_1280_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_2HZ: case (i)
        3'h0: s = lit(slpg_pkg::T_DAH_MS);
        3'h1: s = dark(slpg_pkg::T_2HZ_OFF_MS);
        default: s = 12'h000;
      endcase
      slpg_pkg::PAT_5HZ: case (i)
        3'h0: s = lit(slpg_pkg::T_5HZ_MS);
        3'h1: s = dark(slpg_pkg::T_5HZ_MS);
        default: s = 12'h000;
      endcase
      default: if (i == 3'h0) s = dark(slpg_pkg::T_STEADY_MS); // Off and illegal codes
    endcase
    seg_of = s;
  endfunction : seg_of

  assign cur_seg = seg_of(pat_reg, idx_reg);

  // Interval walk; a new pattern restarts at its first interval
  always_comb begin
    pat_next = pat_reg;
    idx_next = idx_reg;
    ms_next = ms_reg;
    if (pattern != pat_reg) begin
      pat_next = pattern;
      idx_next = 3'h0;
      ms_next = 11'h000;
    end else if (tick) begin
      if (ms_reg + 11'h001 >= cur_seg[10:0]) begin
        ms_next = 11'h000;
        if (idx_reg == 3'(slpg_pkg::MAX_SEGS - 1) ||
            seg_of(pat_reg, idx_reg + 3'h1) == 12'h000) begin
          idx_next = 3'h0;
        end else begin
          idx_next = idx_reg + 3'h1;
        end
      end else begin
        ms_next = ms_reg + 11'h001;
      end
    end
    lamp_next = seg_of(pat_next, idx_next) >> slpg_pkg::DUR_W != 12'h000;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pat_reg <= slpg_pkg::PAT_RST;
      idx_reg <= 3'h0;
      ms_reg <= 11'h000;
      lamp_reg <= 1'b0;
    end else begin
      pat_reg <= pat_next;
      idx_reg <= idx_next;
      ms_reg <= ms_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp = lamp_reg;

endmodule : slpg_player

`default_nettype wire

// [slpg_top.sv]
/*
  Status lamp pattern generator: status registers written by software
  choose one of fourteen blink patterns for each of seven front-panel lamps.
  Assumes one 20 MHz clock, an asynchronous active-low reset and a plain
  register port whose read data stand in the cycle after the read strobe.
*/
// The register addresses and the plain strobed port were decided locally.
// What this block does
// - Every lamp plays one of fourteen patterns
// - Single short and single long flashes
// - Double short flash timing
// - Short then long flash timing
// - Long then short flash timing
// - Double long flash timing
// - Triple short flash timing
// - Short short long flash timing
// - Single long occult, mostly lit
// - Double long occult timing
// - Seven lamps in fixed role order
// - Heartbeat lamp occults every two seconds
// - Logging lamp follows enable and near-full
// - Full storage gives fast blink, no logging
// - Sync lamp follows network alignment state
// - Tracking lamp follows health and tracking
// - Survey lamp follows self-survey progress
`timescale 1ns/1ps
`default_nettype none

module slpg_top #(
  parameter int TICK_CYCLES = slpg_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic lamp_log,
  output logic lamp_sync,
  output logic lamp_track,
  output logic lamp_survey,
  output logic lamp_app,
  output logic lamp_dev,
  output logic lamp_heart
);

  // Software-written status
  logic heart_en_reg, heart_en_next;
  logic [2:0] log_reg, log_next;
  logic [3:0] sync_reg, sync_next;
  logic [3:0] track_reg, track_next;
  logic [2:0] survey_reg, survey_next;
  logic [3:0] app_reg, app_next;
  logic [3:0] dev_reg, dev_next;
  logic [31:0] rdata_reg, rdata_next;

  // Time base
  logic [14:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  // Selected patterns, registered so a player sees clean codes
  logic [3:0] pat_reg [slpg_pkg::NUM_LAMPS];
  logic [3:0] pat_next [slpg_pkg::NUM_LAMPS];
  logic [slpg_pkg::NUM_LAMPS-1:0] lamps;

  // Register writes
  always_comb begin
    heart_en_next = heart_en_reg;
    log_next = log_reg;
    sync_next = sync_reg;
    track_next = track_reg;
    survey_next = survey_reg;
    app_next = app_reg;
    dev_next = dev_reg;
    if (wr_en) begin
      unique case (addr)
        slpg_pkg::REG_CTRL: heart_en_next = wdata[slpg_pkg::CTRL_HEART_BIT];
        slpg_pkg::REG_LOG: begin
          log_next = wdata[2:0];
          // Full storage forbids logging, so the enable is dropped here
          if (wdata[slpg_pkg::LOG_FULL_BIT]) begin
            log_next[slpg_pkg::LOG_EN_BIT] = 1'b0;
          end
        end
        slpg_pkg::REG_SYNC: sync_next = wdata[3:0];
        slpg_pkg::REG_TRACK: track_next = wdata[3:0];
        slpg_pkg::REG_SURVEY: survey_next = wdata[2:0];
        slpg_pkg::REG_APP: app_next = wdata[3:0];
        slpg_pkg::REG_DEV: dev_next = wdata[3:0];
        default: ; // Unmapped and read-only offsets ignore writes
      endcase
    end
  end

  // Register reads; data stand for one cycle only
  always_comb begin
    rdata_next = slpg_pkg::RDATA_RST;
    if (rd_en) begin
      unique case (addr)
        slpg_pkg::REG_CTRL: rdata_next = {31'h0, heart_en_reg};
        slpg_pkg::REG_LOG: rdata_next = {29'h0, log_reg};
        slpg_pkg::REG_SYNC: rdata_next = {28'h0, sync_reg};
        slpg_pkg::REG_TRACK: rdata_next = {28'h0, track_reg};
        slpg_pkg::REG_SURVEY: rdata_next = {29'h0, survey_reg};
        slpg_pkg::REG_APP: rdata_next = {28'h0, app_reg};
        slpg_pkg::REG_DEV: rdata_next = {28'h0, dev_reg};
        slpg_pkg::REG_LAMPS: rdata_next = {25'h0, lamps};
        slpg_pkg::REG_PATS: rdata_next = {4'h0, pat_reg[6], pat_reg[5], pat_reg[4],
                                          pat_reg[3], pat_reg[2], pat_reg[1], pat_reg[0]};
        default: rdata_next = slpg_pkg::RDATA_RST; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      heart_en_reg <= 1'b0;
      log_reg <= 3'h0;
      sync_reg <= 4'h0;
      track_reg <= 4'h0;
      survey_reg <= 3'h0;
      app_reg <= 4'h0;
      dev_reg <= 4'h0;
      rdata_reg <= slpg_pkg::RDATA_RST;
    end else begin
      heart_en_reg <= heart_en_next;
      log_reg <= log_next;
      sync_reg <= sync_next;
      track_reg <= track_next;
      survey_reg <= survey_next;
      app_reg <= app_next;
      dev_reg <= dev_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // Millisecond tick; parameter lets a simulation shorten it
  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 15'h0001;
    if (tick_cnt_reg >= 15'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 15'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Pattern choice per lamp; faults are tested first
  always_comb begin
    // Logging lamp
    if (log_reg[slpg_pkg::LOG_FULL_BIT]) begin
      pat_next[0] = slpg_pkg::PAT_5HZ;
    end else if (log_reg[slpg_pkg::LOG_NEAR_BIT]) begin
      pat_next[0] = log_reg[slpg_pkg::LOG_EN_BIT] ? slpg_pkg::PAT_OCC_DAH
                                                  : slpg_pkg::PAT_DAH;
    end else begin
      pat_next[0] = log_reg[slpg_pkg::LOG_EN_BIT] ? slpg_pkg::PAT_ON
                                                  : slpg_pkg::PAT_OFF;
    end
    // Network sync lamp
    if (sync_reg[slpg_pkg::SYNC_FAULT_BIT]) begin
      pat_next[1] = slpg_pkg::PAT_5HZ;
    end else begin
      case (sync_reg[2:0])
        slpg_pkg::SYNC_COARSE: pat_next[1] = slpg_pkg::PAT_DAH;
        slpg_pkg::SYNC_FINE: pat_next[1] = slpg_pkg::PAT_DAH_DAH;
        slpg_pkg::SYNC_LOCKED: pat_next[1] = slpg_pkg::PAT_ON;
        default: pat_next[1] = slpg_pkg::PAT_OFF; // Network master
      endcase
    end
    // Health and tracking lamp
    if (track_reg[slpg_pkg::TRACK_FAULT_BIT]) begin
      pat_next[2] = slpg_pkg::PAT_5HZ;
    end else begin
      case (track_reg[2:0])
        slpg_pkg::TRK_ACQ: pat_next[2] = slpg_pkg::PAT_DIT;
        slpg_pkg::TRK_TRACKING: pat_next[2] = slpg_pkg::PAT_DAH;
        slpg_pkg::TRK_REF: pat_next[2] = slpg_pkg::PAT_DAH_DIT;
        slpg_pkg::TRK_SELF: pat_next[2] = slpg_pkg::PAT_DAH_DAH;
        slpg_pkg::TRK_GOOD: pat_next[2] = slpg_pkg::PAT_ON;
        default: pat_next[2] = slpg_pkg::PAT_OFF;
      endcase
    end
    // Self-survey lamp
    if (survey_reg[slpg_pkg::SURVEY_FAULT_BIT]) begin
      pat_next[3] = slpg_pkg::PAT_5HZ;
    end else begin
      unique case (survey_reg[1:0])
        slpg_pkg::SRV_OFF: pat_next[3] = slpg_pkg::PAT_OFF;
        slpg_pkg::SRV_INITIAL: pat_next[3] = slpg_pkg::PAT_DIT_DIT;
        slpg_pkg::SRV_FULL: pat_next[3] = slpg_pkg::PAT_DIT_DAH;
        slpg_pkg::SRV_MONITOR: pat_next[3] = slpg_pkg::PAT_ON;
      endcase
    end
    // Application and device lamps take a pattern number directly
    pat_next[4] = (app_reg >= slpg_pkg::PAT_OFF && app_reg <= slpg_pkg::PAT_ON)
                  ? app_reg : slpg_pkg::PAT_OFF;
    pat_next[5] = (dev_reg >= slpg_pkg::PAT_OFF && dev_reg <= slpg_pkg::PAT_ON)
                  ? dev_reg : slpg_pkg::PAT_OFF;
    // Heartbeat is mostly lit with a short dark blip each two seconds
    pat_next[6] = heart_en_reg ? slpg_pkg::PAT_OCC_DAH : slpg_pkg::PAT_OFF;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < slpg_pkg::NUM_LAMPS; i++) begin
        pat_reg[i] <= slpg_pkg::PAT_RST;
      end
    end else begin
      for (int i = 0; i < slpg_pkg::NUM_LAMPS; i++) begin
        pat_reg[i] <= pat_next[i];
      end
    end
  end

  // One player per lamp
  for (genvar g = 0; g < slpg_pkg::NUM_LAMPS; g++) begin : g_lamp
    slpg_player u_player (
      .clock(clock),
      .nrst(nrst),
      .tick(tick_reg),
      .pattern(pat_reg[g]),
      .lamp(lamps[g])
    );
  end

  // Role order: yellow, red, green, yellow, red, green, yellow
  assign lamp_log = lamps[0];
  assign lamp_sync = lamps[1];
  assign lamp_track = lamps[2];
  assign lamp_survey = lamps[3];
  assign lamp_app = lamps[4];
  assign lamp_dev = lamps[5];
  assign lamp_heart = lamps[6];

endmodule : slpg_top

`default_nettype wire

// [slpg_top_properties.sv]
/*
  Port checker for the status lamp pattern generator.
  Assumes it is bound to slpg_top and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module slpg_top_properties #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic lamp_log,
  input wire logic lamp_sync,
  input wire logic lamp_track,
  input wire logic lamp_survey,
  input wire logic lamp_app,
  input wire logic lamp_dev,
  input wire logic lamp_heart
);
  localparam int T = TICK_CYCLES;
  logic app_q, heart_q, app_wr, heart_wr, wrote;
  logic app_q_next, heart_q_next, app_wr_next, heart_wr_next, wrote_next;
  logic [31:0] app_run, heart_run, app_run_next, heart_run_next;
  logic wr_app, wr_log, wr_sync;
  assign wr_app = wr_en && (addr == slpg_pkg::REG_APP);
  assign wr_log = wr_en && (addr == slpg_pkg::REG_LOG);
  assign wr_sync = wr_en && (addr == slpg_pkg::REG_SYNC);

  // Run lengths per level; a write excuses the run it may cut short
  always_comb begin
    app_q_next = lamp_app;
    heart_q_next = lamp_heart;
    app_run_next = (lamp_app != app_q) ? 32'h1 : app_run + 32'h1;
    heart_run_next = (lamp_heart != heart_q) ? 32'h1 : heart_run + 32'h1;
    app_wr_next = ((lamp_app == app_q) && app_wr) || wr_app;
    heart_wr_next = ((lamp_heart == heart_q) && heart_wr)
      || (wr_en && (addr == slpg_pkg::REG_CTRL));
    wrote_next = wrote || wr_en;
  end

  // Helper registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      app_q <= 1'b0;
      heart_q <= 1'b0;
      app_run <= 32'h0;
      heart_run <= 32'h0;
      app_wr <= 1'b1;
      heart_wr <= 1'b1;
      wrote <= 1'b0;
    end else begin
      app_q <= app_q_next;
      heart_q <= heart_q_next;
      app_run <= app_run_next;
      heart_run <= heart_run_next;
      app_wr <= app_wr_next;
      heart_wr <= heart_wr_next;
      wrote <= wrote_next;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_reset_dark: assert property (
    nrst && !$past(nrst) |-> {lamp_log, lamp_sync, lamp_track, lamp_survey,
      lamp_app, lamp_dev, lamp_heart} == 7'h00)
    else $error("lamp lit right after reset");
  chk_idle_dark: assert property (
    !wrote |-> {lamp_log, lamp_sync, lamp_track, lamp_survey, lamp_app, lamp_dev,
      lamp_heart} == 7'h00)
    else $error("lamp lit before any status write");
  chk_app_min_run: assert property (
    (lamp_app != app_q) |-> (app_run >= 79 * T) || app_wr)
    else $error("application lamp interval too short");
  chk_heart_run: assert property (
    (lamp_heart != heart_q) |-> heart_wr
      || (heart_run >= 239 * T - 1 && heart_run <= 240 * T)
      || (heart_run >= 1759 * T - 1 && heart_run <= 1760 * T))
    else $error("heartbeat interval length wrong");
  chk_flash_start: assert property (
    wr_app && (wdata[3:0] inside {[4'h2:4'h9], 4'hC, 4'hD}) |-> ##5 lamp_app [*8])
    else $error("flash pattern did not restart lit");
  chk_occult_start: assert property (
    wr_app && (wdata[3:0] inside {4'hA, 4'hB}) |-> ##5 !lamp_app [*8])
    else $error("occult pattern did not restart dark");
  chk_app_steady: assert property (
    wr_app && (wdata[3:0] == 4'hE) |-> ##5 lamp_app [*8])
    else $error("steady on pattern not lit");
  chk_log_on: assert property (
    wr_log && (wdata[2:0] == 3'h1) |-> ##5 lamp_log [*8])
    else $error("logging lamp not on when enabled");
  chk_log_full: assert property (
    wr_log && wdata[2] |-> ##5 lamp_log [*8])
    else $error("full storage blink did not start lit");
  chk_sync_fault: assert property (
    wr_sync && wdata[3] |-> ##5 lamp_sync [*8])
    else $error("high phase event blink did not start lit");
  chk_sync_off: assert property (
    wr_sync && (wdata[3:0] == 4'h0) |-> ##5 !lamp_sync [*8])
    else $error("sync lamp not off when unsynchronised");
  chk_track_good: assert property (
    wr_en && (addr == slpg_pkg::REG_TRACK) && (wdata[3:0] == 4'h5) |-> ##5 lamp_track [*8])
    else $error("tracking lamp not on for good health");
endmodule : slpg_top_properties

`default_nettype wire

// [slpg_lamp_panel.sv]
/*
  Model of the lamp panel seen by an operator: logs each lamp's runs
  of equal level in clock cycles. Assumes lamps change only after clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module slpg_lamp_panel (
  input wire logic clock,
  input wire logic [6:0] lamps
);
  int runs[7][$];
  logic lvls[7][$];
  int cnt[7] = '{default: 0};
  logic [6:0] prev = 7'h00;

  // A finished run is logged with the level it had
  always @(posedge clock) begin
    for (int l = 0; l < 7; l++) begin
      if (lamps[l] !== prev[l]) begin
        runs[l].push_back(cnt[l]);
        lvls[l].push_back(prev[l]);
        cnt[l] = 1;
      end else begin
        cnt[l]++;
      end
    end
    prev = lamps;
  end

  // Forget history; the run in progress keeps its count
  task automatic clear();
    for (int l = 0; l < 7; l++) begin
      runs[l].delete();
      lvls[l].delete();
    end
  endtask : clear
endmodule : slpg_lamp_panel

`default_nettype wire

// [slpg_top_tb.sv]
/*
  Self-checking bench for the status lamp pattern generator.
  Assumes slpg_pkg, the checker and the lamp panel model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module slpg_top_tb;
  localparam int T = 2; // Short tick keeps two-second patterns cheap
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  wire [6:0] lamps;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  slpg_top #(.TICK_CYCLES(T)) i_slpg_top (.clock(clock), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .lamp_log(lamps[0]),
    .lamp_sync(lamps[1]), .lamp_track(lamps[2]), .lamp_survey(lamps[3]),
    .lamp_app(lamps[4]), .lamp_dev(lamps[5]), .lamp_heart(lamps[6]));
  slpg_lamp_panel i_slpg_lamp_panel (.clock(clock), .lamps(lamps));

  task automatic finish_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd

  // Write lamp l's status word (in lamp order), then read its pattern back
  task automatic map(input int l, input logic [3:0] d, input logic [3:0] p);
    logic [31:0] v;
    wr((l == 6) ? slpg_pkg::REG_CTRL : slpg_pkg::REG_LOG + 8'(4 * l), {28'h0, d});
    repeat (12) @(posedge clock);
    rd(slpg_pkg::REG_PATS, v);
    chk({28'h0, v[4 * l +: 4]}, {28'h0, p});
  endtask : map

  // Interval k of pattern p in ms; zero past the end
  function automatic int seg(input int p, input int k);
    int t[6] = '{default: 0};
    case (p)
      2: t = '{80, 1920, 0, 0, 0, 0};
      3: t = '{240, 1760, 0, 0, 0, 0};
      4: t = '{80, 240, 80, 1600, 0, 0};
      5: t = '{80, 240, 240, 1440, 0, 0};
      6: t = '{240, 240, 80, 1440, 0, 0};
      7: t = '{240, 240, 240, 1280, 0, 0};
      8: t = '{80, 240, 80, 240, 80, 1280};
      9: t = '{80, 240, 80, 240, 240, 1120};
      10: t = '{240, 1760, 0, 0, 0, 0};
      11: t = '{240, 240, 240, 1280, 0, 0};
      12: t = '{240, 260, 0, 0, 0, 0};
      13: t = '{100, 100, 0, 0, 0, 0};
      default: ;
    endcase
    return t[k];
  endfunction : seg

  // Run 0 may be cut short; runs 1..n must match one whole period
  task automatic check_runs(input int l, input int p);
    int n = 0;
    logic lit0 = !(p == 10 || p == 11);
    for (int k = 0; k < 6; k++) begin
      if (seg(p, k) > 0) n++;
    end
    chk(32'(i_slpg_lamp_panel.runs[l].size() > n), 32'h1);
    if (i_slpg_lamp_panel.runs[l].size() > n) begin
      for (int k = 1; k <= n; k++) begin
        chk(32'(i_slpg_lamp_panel.runs[l][k]), 32'(seg(p, k % n) * T));
        chk({31'h0, i_slpg_lamp_panel.lvls[l][k]}, {31'h0, (k % 2 == 0) == lit0});
      end
    end
  endtask : check_runs

  // Two lamps play two patterns side by side, plus the heartbeat once
  task automatic round(input int pa, input int pd, input bit heart);
    if (heart) wr(slpg_pkg::REG_CTRL, 32'h1);
    wr(slpg_pkg::REG_APP, 32'(pa));
    wr(slpg_pkg::REG_DEV, 32'(pd));
    repeat (6) @(posedge clock);
    @(negedge clock);
    i_slpg_lamp_panel.clear();
    repeat (2240 * T + 40) @(posedge clock);
    @(negedge clock);
    check_runs(4, pa);
    check_runs(5, pd);
    if (heart) check_runs(6, 10);
  endtask : round

  // Hang guard, about twice the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    logic [31:0] v;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    rd(slpg_pkg::REG_PATS, v);
    chk(v, 32'h0111_1111);
    rd(slpg_pkg::REG_LAMPS, v);
    chk(v, 32'h0000_0000);
    rd(8'h40, v);
    chk(v, 32'h0000_0000);
    wr(slpg_pkg::REG_PATS, 32'hFFFF_FFFF);
    rd(slpg_pkg::REG_PATS, v);
    chk(v, 32'h0111_1111);
    map(0, 4'h1, slpg_pkg::PAT_ON);
    map(0, 4'h2, slpg_pkg::PAT_DAH);
    map(0, 4'h3, slpg_pkg::PAT_OCC_DAH);
    map(0, 4'h0, slpg_pkg::PAT_OFF);
    map(0, 4'h5, slpg_pkg::PAT_5HZ);
    rd(slpg_pkg::REG_LOG, v);
    chk(v, 32'h0000_0004);
    map(0, 4'h7, slpg_pkg::PAT_5HZ);
    map(1, 4'h1, slpg_pkg::PAT_DAH);
    map(1, 4'h2, slpg_pkg::PAT_DAH_DAH);
    map(1, 4'h3, slpg_pkg::PAT_ON);
    map(1, 4'hB, slpg_pkg::PAT_5HZ);
    map(1, 4'h0, slpg_pkg::PAT_OFF);
    map(2, 4'h1, slpg_pkg::PAT_DIT);
    map(2, 4'h2, slpg_pkg::PAT_DAH);
    map(2, 4'h3, slpg_pkg::PAT_DAH_DIT);
    map(2, 4'h4, slpg_pkg::PAT_DAH_DAH);
    map(2, 4'h5, slpg_pkg::PAT_ON);
    map(2, 4'hD, slpg_pkg::PAT_5HZ);
    map(2, 4'h0, slpg_pkg::PAT_OFF);
    map(3, 4'h1, slpg_pkg::PAT_DIT_DIT);
    map(3, 4'h2, slpg_pkg::PAT_DIT_DAH);
    map(3, 4'h3, slpg_pkg::PAT_ON);
    map(3, 4'h7, slpg_pkg::PAT_5HZ);
    map(3, 4'h0, slpg_pkg::PAT_OFF);
    map(6, 4'h1, slpg_pkg::PAT_OCC_DAH);
    map(6, 4'h0, slpg_pkg::PAT_OFF);
    for (int i = 0; i < 6; i++) begin
      round(8 + i, 2 + i, i == 0);
    end
    wr(slpg_pkg::REG_APP, 32'hE);
    wr(slpg_pkg::REG_DEV, 32'hF);
    repeat (10) @(posedge clock);
    @(negedge clock);
    i_slpg_lamp_panel.clear();
    repeat (600) @(posedge clock);
    @(negedge clock);
    chk(32'(i_slpg_lamp_panel.runs[4].size() + i_slpg_lamp_panel.runs[5].size()), 32'h0);
    chk({30'h0, lamps[5:4]}, 32'h1);
    finish_test();
  end
endmodule : slpg_top_tb

bind slpg_top slpg_top_properties #(.TICK_CYCLES(TICK_CYCLES)) i_slpg_top_properties (
  .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .lamp_log(lamp_log), .lamp_sync(lamp_sync), .lamp_track(lamp_track),
  .lamp_survey(lamp_survey), .lamp_app(lamp_app), .lamp_dev(lamp_dev),
  .lamp_heart(lamp_heart));

`default_nettype wire
